// ===== common/tscf_map.svh
// Register offsets, field positions, reset values and sizes of the
// transaction security and context front end.
// Assumes inclusion by bare name from the modules; the package does not include it.
// Functional notes
// - Every client transaction is first classed Secure or Non-secure.
// - Access status and origin security state are carried separately.
// - An ID flag tells if the lookup vector space exists.
// - With lookup space, the security index selects one vector bit.
// - Without lookup space, origin comes from source or access status.
// - Non-secure access reaches Non-secure copy; Secure reaches Secure copy.
// - Config access picks bank by access level; clients by origin.
// - Context registers and global commands are never banked.
// - Each transaction gets exactly one outcome: bypass, fault, translate.
// - Two-stage support allows at most two contexts per transaction.
// - Equal stream tags with equal origin state map to the same context.
// - Stream tag is derived from security bit, read flag and ID.
// - A four-bit ID field reports implemented tag bits, 0 to 15.
// - Stage-one table addresses pass through stage two; failure faults.
// - Lookaside cache of walks with a software invalidate command.
`ifndef TSCF_MAP_SVH
`define TSCF_MAP_SVH
`define TSCF_OFS_ID0      8'h00
`define TSCF_OFS_ID1      8'h04
`define TSCF_OFS_CR       8'h08
`define TSCF_OFS_STAT     8'h0c
`define TSCF_OFS_TLBINV   8'h10
`define TSCF_OFS_LOOKUP   8'h80
`define TSCF_PAGE_STC     4'h2
`define TSCF_PAGE_CTX     4'h4
`define TSCF_TAG_W        4
`define TSCF_ID_W         4
`define TSCF_IDX_W        5
`define TSCF_LOOKUP_PRES  1'b1
`define TSCF_CR_BYPASS    0
`define TSCF_CR_FAULT     1
`define TSCF_CR_SRCMODE   2
`define TSCF_CR_RST       3'h0
`define TSCF_LOOKUP_RST   32'h0000_0000
`define TSCF_CTX_RST      32'h0000_0000
`define TSCF_STC_RST      6'h00
`endif

// ===== common/tscf_pkg.sv
// Types shared by the front end modules.
// Assumes tscf_map.svh is on the include path.
package tscf_pkg;
    typedef enum logic [1:0] {
        TSCF_ACT_BYPASS,
        TSCF_ACT_FAULT,
        TSCF_ACT_XLATE
    } tscf_act_t;
    typedef logic [1:0] tscf_ctx_t;
    typedef struct packed {
        logic      twoStage;
        tscf_ctx_t ctx2;
        tscf_ctx_t ctx1;
        logic      valid;
    } tscf_stc_t;
endpackage

// ===== common/tscf_ctx_if.sv
// Carrier between the front end and its context selector.
// Assumes tscf_pkg compiled first.
`timescale 1ns/1ps
interface tscf_ctx_if;
    logic                clientBypass;
    logic                faultUnmatched;
    tscf_pkg::tscf_stc_t entry;
    tscf_pkg::tscf_act_t action;
    tscf_pkg::tscf_ctx_t ctx1;
    tscf_pkg::tscf_ctx_t ctx2;
    logic                twoStage;
    modport front (output clientBypass, faultUnmatched, entry,
                   input action, ctx1, ctx2, twoStage);
    modport sel (input clientBypass, faultUnmatched, entry,
                 output action, ctx1, ctx2, twoStage);
endinterface

// ===== core/tscf_stream_tag.sv
// Stream tag derivation from interconnect identification.
// Assumes inputs on the same clock; output is combinational.
`timescale 1ns/1ps
`include "tscf_map.svh"
module tscf_stream_tag (
    input  wire logic                   accessNs,
    input  wire logic                   isRead,
    input  wire logic [`TSCF_ID_W-1:0]  txId,
    output logic      [`TSCF_TAG_W-1:0] tag
);
    // Only two ID bits fit beside security and direction
    always_comb begin
        tag = {accessNs, isRead, txId[1:0]};
    end
endmodule

// ===== core/tscf_ctx_select.sv
// Outcome and context choice for one classified transaction.
// Assumes the front end has already picked the bank entry.
`timescale 1ns/1ps
module tscf_ctx_select (
    tscf_ctx_if.sel cif
);
    always_comb begin
        cif.ctx1     = cif.entry.ctx1;
        cif.ctx2     = cif.entry.ctx2;
        cif.twoStage = 1'b0;
        if (cif.clientBypass) begin
            cif.action = tscf_pkg::TSCF_ACT_BYPASS;
        end else if (!cif.entry.valid) begin
            // Unmatched stream: fault or pass as configured
            cif.action = cif.faultUnmatched ? tscf_pkg::TSCF_ACT_FAULT
                                            : tscf_pkg::TSCF_ACT_BYPASS;
        end else begin
            cif.action   = tscf_pkg::TSCF_ACT_XLATE;
            cif.twoStage = cif.entry.twoStage;
        end
    end
endmodule

// ===== core/tscf_front_end.sv
// Security classification, banked configuration and context choice.
// Assumes clients and register master run on clk; no waits.
`timescale 1ns/1ps
`include "tscf_map.svh"
module tscf_front_end (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic [7:0]                  regAddr,
    input  wire logic [31:0]                 regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    input  wire logic                        regSecure,
    output logic      [31:0]                 regRdata,
    input  wire logic                        txValid,
    input  wire logic                        txAccessNs,
    input  wire logic                        txSrcSecure,
    input  wire logic [`TSCF_IDX_W-1:0]      txSecIndex,
    input  wire logic                        txRead,
    input  wire logic [`TSCF_ID_W-1:0]       txId,
    output logic                             outValid,
    output logic                             outSecure,
    output logic                             outAccessNs,
    output logic      [`TSCF_TAG_W-1:0]      outTag,
    output tscf_pkg::tscf_act_t              outAction,
    output tscf_pkg::tscf_ctx_t              outCtx1,
    output tscf_pkg::tscf_ctx_t              outCtx2,
    output logic                             outTwoStage,
    input  wire logic                        walkValid,
    input  wire tscf_pkg::tscf_ctx_t         walkCtx,
    input  wire logic [31:0]                 walkInAddr,
    output logic                             walkDone,
    output logic      [31:0]                 walkPa,
    output logic                             walkFault
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic inPage(input logic [7:0] a,
                                    input logic [3:0] pg);
        inPage = (a[7:4] == pg);
    endfunction

    function automatic logic [1:0] slot(input logic [7:0] a);
        slot = a[3:2];
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic [2:0]          crS_r;
    logic [2:0]          crNs_r;
    tscf_pkg::tscf_stc_t stcS_r  [4];
    tscf_pkg::tscf_stc_t stcNs_r [4];
    logic [31:0]         ctxReg_r [4];
    logic [31:0]         lookup_r;
    logic                tlbValid_r;
    tscf_pkg::tscf_ctx_t tlbCtx_r;
    logic [15:0]         tlbInPg_r;
    logic [15:0]         tlbPa_r;
    logic [15:0]         hitCnt_r;
    logic [15:0]         faultCnt_r;
    logic [31:0]         rdata_r;

    logic                wrCr;
    logic                wrStc;
    logic                wrCtx;
    logic                wrInv;
    logic                wrLookup;
    logic                lookupBit;
    logic                origin;
    logic [2:0]          crSel;
    logic [`TSCF_TAG_W-1:0] tag;
    logic [15:0]         inPg;
    logic [15:0]         limit;
    logic [15:0]         base;
    logic                hit;
    logic                walkBad;
    logic [15:0]         paPg;

    tscf_ctx_if cif ();

    // ****************************************
    // Register writes
    // ****************************************
    always_comb begin
        wrCr     = regWr && regAddr == `TSCF_OFS_CR;
        wrInv    = regWr && regAddr == `TSCF_OFS_TLBINV;
        wrStc    = regWr && inPage(regAddr, `TSCF_PAGE_STC);
        wrCtx    = regWr && inPage(regAddr, `TSCF_PAGE_CTX);
        // Vector is only writable from the Secure side
        wrLookup = regWr && regSecure && regAddr == `TSCF_OFS_LOOKUP;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            crS_r  <= `TSCF_CR_RST;
            crNs_r <= `TSCF_CR_RST;
        end else if (wrCr && regSecure) begin
            crS_r  <= regWdata[2:0];
        end else if (wrCr) begin
            crNs_r <= regWdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                stcS_r[i]  <= `TSCF_STC_RST;
                stcNs_r[i] <= `TSCF_STC_RST;
            end
        end else if (wrStc && regSecure) begin
            stcS_r[slot(regAddr)]  <= regWdata[5:0];
        end else if (wrStc) begin
            stcNs_r[slot(regAddr)] <= regWdata[5:0];
        end
    end

    // Context registers are shared by both worlds
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                ctxReg_r[i] <= `TSCF_CTX_RST;
            end
        end else if (wrCtx) begin
            ctxReg_r[slot(regAddr)] <= regWdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lookup_r <= `TSCF_LOOKUP_RST;
        end else if (wrLookup) begin
            lookup_r <= regWdata;
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (!regRd) begin
            rdata_r <= 32'h0000_0000;
        end else if (regAddr == `TSCF_OFS_ID0) begin
            rdata_r <= 32'(`TSCF_TAG_W);
        end else if (regAddr == `TSCF_OFS_ID1) begin
            rdata_r <= 32'(`TSCF_LOOKUP_PRES);
        end else if (regAddr == `TSCF_OFS_CR) begin
            rdata_r <= 32'(regSecure ? crS_r : crNs_r);
        end else if (regAddr == `TSCF_OFS_STAT) begin
            rdata_r <= {faultCnt_r, hitCnt_r};
        end else if (regAddr == `TSCF_OFS_LOOKUP) begin
            // Read-back lets Secure software verify the vector
            rdata_r <= regSecure ? lookup_r : 32'h0000_0000;
        end else if (inPage(regAddr, `TSCF_PAGE_STC)) begin
            rdata_r <= 32'(regSecure ? stcS_r[slot(regAddr)]
                                     : stcNs_r[slot(regAddr)]);
        end else if (inPage(regAddr, `TSCF_PAGE_CTX)) begin
            rdata_r <= ctxReg_r[slot(regAddr)];
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign regRdata = rdata_r;

    // ****************************************
    // Classification and context choice
    // ****************************************
    tscf_stream_tag u_tag (
        .accessNs (txAccessNs),
        .isRead   (txRead),
        .txId     (txId),
        .tag      (tag)
    );

    always_comb begin
        // Vector bit 0 marks a Secure device
        lookupBit = lookup_r[txSecIndex];
        if (`TSCF_LOOKUP_PRES) begin
            origin = !lookupBit;
        end else if (crS_r[`TSCF_CR_SRCMODE]) begin
            origin = !txAccessNs;
        end else begin
            origin = txSrcSecure;
        end
        crSel              = origin ? crS_r : crNs_r;
        cif.clientBypass   = crSel[`TSCF_CR_BYPASS];
        cif.faultUnmatched = crSel[`TSCF_CR_FAULT];
        // Same tag, same bank entry
        cif.entry = origin ? stcS_r[tag[1:0]] : stcNs_r[tag[1:0]];
    end

    tscf_ctx_select u_sel (
        .cif (cif.sel)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            outValid    <= 1'b0;
            outSecure   <= 1'b0;
            outAccessNs <= 1'b0;
            outTag      <= '0;
            outAction   <= tscf_pkg::TSCF_ACT_BYPASS;
            outCtx1     <= '0;
            outCtx2     <= '0;
            outTwoStage <= 1'b0;
        end else begin
            outValid    <= txValid;
            outSecure   <= origin;
            outAccessNs <= txAccessNs;
            outTag      <= tag;
            outAction   <= cif.action;
            outCtx1     <= cif.ctx1;
            outCtx2     <= cif.ctx2;
            outTwoStage <= cif.twoStage;
        end
    end

    // ****************************************
    // Stage-two walk of table addresses
    // ****************************************
    always_comb begin
        inPg    = walkInAddr[31:16];
        limit   = ctxReg_r[walkCtx][31:16];
        base    = ctxReg_r[walkCtx][15:0];
        hit     = tlbValid_r && tlbCtx_r == walkCtx && tlbInPg_r == inPg;
        walkBad = !hit && inPg >= limit;
        paPg    = hit ? tlbPa_r : 16'(base + inPg);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            walkDone  <= 1'b0;
            walkFault <= 1'b0;
            walkPa    <= 32'h0000_0000;
        end else begin
            walkDone  <= walkValid;
            walkFault <= walkValid && walkBad;
            walkPa    <= walkBad ? 32'h0000_0000 : {paPg, walkInAddr[15:0]};
        end
    end

    // A fill in the invalidate cycle wins; software reissues if needed
    always_ff @(posedge clk) begin
        if (reset) begin
            tlbValid_r <= 1'b0;
            tlbCtx_r   <= '0;
            tlbInPg_r  <= 16'h0000;
            tlbPa_r    <= 16'h0000;
        end else if (walkValid && !hit && !walkBad) begin
            tlbValid_r <= 1'b1;
            tlbCtx_r   <= walkCtx;
            tlbInPg_r  <= inPg;
            tlbPa_r    <= paPg;
        end else if (wrInv) begin
            tlbValid_r <= 1'b0;
        end
    end

    // Counters saturate rather than wrap
    always_ff @(posedge clk) begin
        if (reset) begin
            hitCnt_r   <= 16'h0000;
            faultCnt_r <= 16'h0000;
        end else begin
            if (walkValid && hit && hitCnt_r != 16'hffff) begin
                hitCnt_r <= hitCnt_r + 16'h0001;
            end
            if (walkValid && walkBad && faultCnt_r != 16'hffff) begin
                faultCnt_r <= faultCnt_r + 16'h0001;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence sReadId0;
        regRd && regAddr == `TSCF_OFS_ID0;
    endsequence

    sequence sReadId1;
        regRd && regAddr == `TSCF_OFS_ID1;
    endsequence

    AST_ORIGIN: assert property (
        txValid |=> outValid && outSecure == !$past(lookupBit))
        else $error("origin state not from lookup bit");

    AST_STATUS_KEPT: assert property (
        txValid |=> outAccessNs == $past(txAccessNs))
        else $error("access status lost");

    AST_ID_WIDTH: assert property (
        sReadId0 |=> regRdata == 32'(`TSCF_TAG_W))
        else $error("tag width field wrong");

    AST_ID_LOOKUP: assert property (
        sReadId1 |=> regRdata[0] == `TSCF_LOOKUP_PRES)
        else $error("lookup present flag wrong");

    AST_BANK_NS: assert property (
        wrCr && !regSecure |=> crNs_r == $past(regWdata[2:0])
                               && $stable(crS_r))
        else $error("non-secure write hit wrong copy");

    AST_BYPASS: assert property (
        txValid && cif.clientBypass |=>
            outAction == tscf_pkg::TSCF_ACT_BYPASS && !outTwoStage)
        else $error("bypass not chosen");

    AST_TWO_CTX: assert property (
        outTwoStage |-> outAction == tscf_pkg::TSCF_ACT_XLATE)
        else $error("second context without translation");

    AST_SAME_TAG: assert property (
        txValid && !regWr ##1 txValid && tag == $past(tag)
            && origin == $past(origin)
        |=> outCtx1 == $past(outCtx1) && outAction == $past(outAction))
        else $error("same tag gave different context");

    AST_NOT_BANKED: assert property (
        wrCtx |=> ctxReg_r[$past(regAddr[3:2])] == $past(regWdata))
        else $error("context register write lost");

    AST_WALK_FAULT: assert property (
        walkValid && walkBad |=> walkDone && walkFault ##1 !walkFault
            || walkValid)
        else $error("stage two failure not reported");

    AST_TLB_INV: assert property (
        wrInv && !walkValid |=> !tlbValid_r)
        else $error("invalidate did not clear cache");
endmodule

// ===== dv/tscf_client_model.sv
// Client device model: issues one transaction per call of send.
// Assumes the bench clock and that send is called after reset.
`timescale 1ns/1ps
`include "tscf_map.svh"
module tscf_client_model (
    input  wire logic                  clk,
    output logic                       txValid,
    output logic                       txAccessNs,
    output logic                       txSrcSecure,
    output logic [`TSCF_IDX_W-1:0]     txSecIndex,
    output logic                       txRead,
    output logic [`TSCF_ID_W-1:0]      txId
);
    initial begin
        txValid     = 1'b0;
        txAccessNs  = 1'b0;
        txSrcSecure = 1'b0;
        txSecIndex  = '0;
        txRead      = 1'b0;
        txId        = '0;
    end
    // Idle fields flip, so a stale value can never pass for a live one
    task automatic send(input logic ns, input logic [4:0] idx,
                        input logic rd, input logic [3:0] id);
        @(posedge clk);
        txValid     <= 1'b1;
        txAccessNs  <= ns;
        txSrcSecure <= ~ns;
        txSecIndex  <= idx;
        txRead      <= rd;
        txId        <= id;
        @(posedge clk);
        txValid     <= 1'b0;
        txAccessNs  <= ~ns;
        txSrcSecure <= ns;
        txSecIndex  <= ~idx;
        txRead      <= ~rd;
        txId        <= ~id;
    endtask
    // Two equal requests on consecutive edges, for the same-tag check
    task automatic send_pair(input logic ns, input logic [4:0] idx,
                             input logic rd, input logic [3:0] id);
        @(posedge clk);
        txValid     <= 1'b1;
        txAccessNs  <= ns;
        txSrcSecure <= ~ns;
        txSecIndex  <= idx;
        txRead      <= rd;
        txId        <= id;
        send(ns, idx, rd, id);
    endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the security and context front end.
// Assumes tscf_pkg and tscf_map.svh are compiled and on the path.
`timescale 1ns/1ps
`include "tscf_map.svh"
module tb_top;
    logic                     clk, reset, regWr, regRd, regSecure;
    logic [7:0]               regAddr;
    logic [31:0]              regWdata, regRdata, walkInAddr, walkPa;
    logic                     txValid, txAccessNs, txSrcSecure, txRead;
    logic [`TSCF_IDX_W-1:0]   txSecIndex;
    logic [`TSCF_ID_W-1:0]    txId;
    logic                     outValid, outSecure, outAccessNs;
    logic                     outTwoStage, walkValid, walkDone, walkFault;
    logic [`TSCF_TAG_W-1:0]   outTag;
    tscf_pkg::tscf_act_t      outAction;
    tscf_pkg::tscf_ctx_t      outCtx1, outCtx2, walkCtx;
    int                       err_count, cmp_count;

    tscf_front_end dut_u (
        .clk(clk), .reset(reset), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regSecure(regSecure), .regRdata(regRdata),
        .txValid(txValid), .txAccessNs(txAccessNs),
        .txSrcSecure(txSrcSecure), .txSecIndex(txSecIndex),
        .txRead(txRead), .txId(txId), .outValid(outValid),
        .outSecure(outSecure), .outAccessNs(outAccessNs),
        .outTag(outTag), .outAction(outAction), .outCtx1(outCtx1),
        .outCtx2(outCtx2), .outTwoStage(outTwoStage),
        .walkValid(walkValid), .walkCtx(walkCtx), .walkInAddr(walkInAddr),
        .walkDone(walkDone), .walkPa(walkPa), .walkFault(walkFault)
    );
    tscf_client_model cli_u (
        .clk(clk), .txValid(txValid), .txAccessNs(txAccessNs),
        .txSrcSecure(txSrcSecure), .txSecIndex(txSecIndex),
        .txRead(txRead), .txId(txId)
    );

    initial clk = 1'b0;
    always #4 clk = ~clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic s,
                      input logic [31:0] d);
        @(posedge clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regSecure <= s;
        regWdata  <= d;
        @(posedge clk);
        regWr     <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic s,
                      input logic [31:0] e);
        @(posedge clk);
        regRd     <= 1'b1;
        regAddr   <= a;
        regSecure <= s;
        @(posedge clk);
        regRd     <= 1'b0;
        #1 chk(regRdata, e);
    endtask
    task automatic walk(input logic [31:0] ia, input logic [31:0] pa,
                        input logic f);
        @(posedge clk);
        walkValid  <= 1'b1;
        walkCtx    <= 2'h0;
        walkInAddr <= ia;
        @(posedge clk);
        walkValid  <= 1'b0;
        walkCtx    <= 2'h3;
        walkInAddr <= ~ia;
        #1 chk(walkPa, pa);
        chk(32'({walkDone, walkFault}), 32'({1'b1, f}));
    endtask
    // Expected tag follows the chosen {accessNs, read, id[1:0]} layout
    task automatic tx(input logic ns, input logic [4:0] idx,
                      input logic rd, input logic [3:0] id,
                      input logic sec, input tscf_pkg::tscf_act_t act,
                      input logic [1:0] c1, input logic [1:0] c2,
                      input logic two);
        cli_u.send(ns, idx, rd, id);
        #1 chk(32'({outValid, outSecure, outAccessNs}),
               32'({1'b1, sec, ns}));
        chk(32'(outTag), 32'({ns, rd, id[1:0]}));
        chk(32'(outAction), 32'(act));
        if (act == tscf_pkg::TSCF_ACT_XLATE) begin
            chk(32'({outCtx1, outTwoStage}), 32'({c1, two}));
        end
        if (two) begin
            chk(32'(outCtx2), 32'(c2));
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {reset, regWr, regRd, regSecure, walkValid} = 5'h10;
        regAddr  = 8'h00;
        regWdata = 32'h0000_0000;
        walkInAddr = 32'h0000_0000;
        walkCtx  = 2'h0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(`TSCF_OFS_ID0, 1'b0, 32'h0000_0004);
        rd(`TSCF_OFS_ID1, 1'b1, 32'h0000_0001);
        @(posedge clk);
        #1 chk(regRdata, 32'h0000_0000);
        wr(`TSCF_OFS_ID0, 1'b1, 32'hffff_ffff);
        rd(`TSCF_OFS_ID0, 1'b1, 32'h0000_0004);
        wr(8'hfc, 1'b1, 32'hffff_ffff);
        rd(8'hfc, 1'b1, 32'h0000_0000);
        // Lookup still at reset: every index classes Secure
        tx(1'b1, 5'h04, 1'b0, 4'h1, 1'b1, tscf_pkg::TSCF_ACT_BYPASS,
           2'h0, 2'h0, 1'b0);
        wr(`TSCF_OFS_LOOKUP, 1'b1, 32'hffff_fff7);
        rd(`TSCF_OFS_LOOKUP, 1'b1, 32'hffff_fff7);
        wr(`TSCF_OFS_LOOKUP, 1'b0, 32'h0000_0000);
        rd(`TSCF_OFS_LOOKUP, 1'b0, 32'h0000_0000);
        rd(`TSCF_OFS_LOOKUP, 1'b1, 32'hffff_fff7);
        wr(`TSCF_OFS_CR, 1'b0, 32'h0000_0001);
        wr(`TSCF_OFS_CR, 1'b1, 32'h0000_0002);
        rd(`TSCF_OFS_CR, 1'b0, 32'h0000_0001);
        rd(`TSCF_OFS_CR, 1'b1, 32'h0000_0002);
        wr(8'h24, 1'b1, 32'h0000_002d);
        wr(8'h24, 1'b0, 32'h0000_0007);
        rd(8'h24, 1'b1, 32'h0000_002d);
        rd(8'h24, 1'b0, 32'h0000_0007);
        wr(8'h40, 1'b0, 32'h0010_0100);
        rd(8'h40, 1'b1, 32'h0010_0100);
        // Walks run before any faulting client traffic
        walk(32'h0020_1234, 32'h0000_0000, 1'b1);
        walk(32'h0001_1234, 32'h0101_1234, 1'b0);
        walk(32'h0001_1234, 32'h0101_1234, 1'b0);
        rd(`TSCF_OFS_STAT, 1'b0, 32'h0001_0001);
        wr(`TSCF_OFS_TLBINV, 1'b0, 32'h0000_0000);
        walk(32'h0001_1234, 32'h0101_1234, 1'b0);
        rd(`TSCF_OFS_STAT, 1'b1, 32'h0001_0001);
        // Secure origin with Non-secure access status
        tx(1'b1, 5'h03, 1'b1, 4'h1, 1'b1, tscf_pkg::TSCF_ACT_XLATE,
           2'h2, 2'h1, 1'b1);
        tx(1'b1, 5'h04, 1'b0, 4'h1, 1'b0, tscf_pkg::TSCF_ACT_BYPASS,
           2'h0, 2'h0, 1'b0);
        wr(`TSCF_OFS_CR, 1'b0, 32'h0000_0000);
        tx(1'b1, 5'h04, 1'b1, 4'h1, 1'b0, tscf_pkg::TSCF_ACT_XLATE,
           2'h3, 2'h0, 1'b0);
        tx(1'b0, 5'h04, 1'b1, 4'h2, 1'b0, tscf_pkg::TSCF_ACT_BYPASS,
           2'h0, 2'h0, 1'b0);
        tx(1'b0, 5'h03, 1'b0, 4'h2, 1'b1, tscf_pkg::TSCF_ACT_FAULT,
           2'h0, 2'h0, 1'b0);
        tx(1'b1, 5'h03, 1'b1, 4'h5, 1'b1, tscf_pkg::TSCF_ACT_XLATE,
           2'h2, 2'h1, 1'b1);
        // Back-to-back equal tags feed the same-tag property
        cli_u.send_pair(1'b1, 5'h03, 1'b1, 4'h1);
        #1 chk(32'({outAction, outCtx1, outCtx2, outTwoStage}),
               32'({tscf_pkg::TSCF_ACT_XLATE, 2'h2, 2'h1, 1'b1}));
        finish_test();
    end

    initial begin
        #20000;
        err_count++;
        finish_test();
    end
endmodule
